// file: pkg/dpwm_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DPWM_REGS_SVH
`define DPWM_REGS_SVH
`define DPWM_OFF_DUTY_LIMIT 4'h0
`define DPWM_OFF_COEF_BASE 4'h1
`define DPWM_OFF_VOUT 4'hC
`define DPWM_OFF_IOUT 4'hD
`define DPWM_OFF_TEMP 4'hE
`define DPWM_OFF_STATUS 4'hF
`define DPWM_NUM_COEF 11
`define DPWM_DCL_FF_BIT 8
`define DPWM_DCL_RESET 9'h0C0
`define DPWM_WINDOW_RESET 8'h10
`define DPWM_CLK_HZ 125000000
`define DPWM_SWITCH_HZ 500000
`define DPWM_SAMPLE_HZ 700
`define DPWM_SWITCH_CYCLES (`DPWM_CLK_HZ / `DPWM_SWITCH_HZ)
// Spacing of conversions, well inside the per-quantity rate floor
`define DPWM_SAMPLE_CYCLES 6000
`define DPWM_TEMP_REF 8'h40
`endif

// file: pkg/dpwm_pkg.sv
// Types for the digital PWM loop and monitor
package dpwm_pkg;
   typedef enum logic [1:0] {
      DPWM_CH_VOUT = 2'b00,
      DPWM_CH_IOUT = 2'b01,
      DPWM_CH_TEMP = 2'b10
   } dpwm_chan_type;
   typedef enum logic [1:0] {
      DPWM_MODE_LINEAR = 2'b00,
      DPWM_MODE_LOW = 2'b01,
      DPWM_MODE_HIGH = 2'b10
   } dpwm_mode_type;
endpackage : dpwm_pkg

// file: verilog/dpwm_core.sv
// Digital PWM control loop with compensation filter and monitoring
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "dpwm_regs.svh"
module dpwm_core
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Loop error and converter samples
   input wire logic [7:0] loop_error,
   input wire logic [7:0] adc_data,
   input wire logic adc_valid,
   output logic [1:0] adc_channel,
   output logic adc_start,
   // PWM output
   output logic pwm_out,
   output logic [7:0] duty_cycle,
   output logic cycle_start
);
   import dpwm_pkg::*;

   localparam int SW_CYC = `DPWM_SWITCH_CYCLES;
   localparam int SMP_CYC = `DPWM_SAMPLE_CYCLES;
   localparam int NCOEF = `DPWM_NUM_COEF;

   // Software-visible state
   logic [8:0] duty_limit_reg;
   logic [7:0] window_reg;
   logic [7:0] coef_reg [NCOEF];
   logic [7:0] output_voltage_reading;
   logic [7:0] output_current_reading;
   logic [7:0] temperature_reading;
   // Shadow copies used by the loop
   logic [8:0] act_limit_reg;
   logic [7:0] act_window_reg;
   logic [7:0] act_coef_reg [NCOEF];
   // Bus
   logic ack_reg;
   // Switching cycle
   logic [7:0] phase_reg;
   logic boundary;
   // Filter
   logic signed [23:0] x1_reg, x2_reg, x3_reg;
   logic signed [23:0] y1_reg, y2_reg, y3_reg;
   logic signed [23:0] y_next;
   logic [7:0] lin_duty;
   logic [7:0] duty_next;
   logic [7:0] duty_reg;
   dpwm_mode_type mode;
   // Monitor
   logic [19:0] smp_cnt_reg;
   dpwm_chan_type chan_reg;

   assign boundary = (phase_reg == 8'(SW_CYC - 1));

   // Bus access: one wait state, answer on the second edge
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= (avs_read || avs_write) && !ack_reg;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
   end

   // Register writes
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         duty_limit_reg <= `DPWM_DCL_RESET;
         window_reg <= `DPWM_WINDOW_RESET;
         for (int i = 0; i < NCOEF; i++)
            coef_reg[i] <= 8'h00;
      end
      else if (avs_write && !avs_waitrequest)
      begin
         if (avs_address == `DPWM_OFF_DUTY_LIMIT)
         begin
            duty_limit_reg <= avs_writedata[8:0];
            window_reg <= avs_writedata[23:16];
         end
         else if (avs_address >= `DPWM_OFF_COEF_BASE &&
                  avs_address < `DPWM_OFF_VOUT)
            coef_reg[avs_address - `DPWM_OFF_COEF_BASE] <=
               avs_writedata[7:0];
      end
   end

   // Register reads
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && avs_waitrequest && !ack_reg)
      begin
         avs_readdata <= 32'h0000_0000;
         if (avs_address == `DPWM_OFF_DUTY_LIMIT)
            avs_readdata <= {8'h00, window_reg, 7'h00, duty_limit_reg};
         else if (avs_address >= `DPWM_OFF_COEF_BASE &&
                  avs_address < `DPWM_OFF_VOUT)
            avs_readdata <= {24'h000000,
               coef_reg[avs_address - `DPWM_OFF_COEF_BASE]};
         else if (avs_address == `DPWM_OFF_VOUT)
            avs_readdata <= {24'h000000, output_voltage_reading};
         else if (avs_address == `DPWM_OFF_IOUT)
            avs_readdata <= {24'h000000, output_current_reading};
         else if (avs_address == `DPWM_OFF_TEMP)
            avs_readdata <= {24'h000000, temperature_reading};
         else if (avs_address == `DPWM_OFF_STATUS)
            avs_readdata <= {22'h000000, mode, duty_reg};
      end
   end

   // Switching cycle counter
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         phase_reg <= 8'h00;
      else if (boundary)
         phase_reg <= 8'h00;
      else
         phase_reg <= phase_reg + 8'h01;
   end

   // Shadow settings load at the cycle boundary
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         act_limit_reg <= `DPWM_DCL_RESET;
         act_window_reg <= `DPWM_WINDOW_RESET;
         for (int i = 0; i < NCOEF; i++)
            act_coef_reg[i] <= 8'h00;
      end
      else if (boundary)
      begin
         act_limit_reg <= duty_limit_reg;
         act_window_reg <= window_reg;
         for (int i = 0; i < NCOEF; i++)
            act_coef_reg[i] <= coef_reg[i];
      end
   end

   // Third-order filter: C0..C3 numerator, B1..B3 feedback
   function automatic logic signed [23:0] num_term(
      input logic [7:0] hi,
      input logic [7:0] lo,
      input logic signed [23:0] x);
      logic signed [15:0] c;
      logic signed [39:0] p;
      c = $signed({hi, lo});
      p = 40'(c * x);
      return p[31:8];
   endfunction : num_term

   function automatic logic signed [23:0] den_term(
      input logic [7:0] b,
      input logic signed [23:0] y);
      logic signed [31:0] p;
      p = 32'($signed(b) * y);
      return 24'(p >>> 6);
   endfunction : den_term

   always_comb
   begin
      logic signed [23:0] x0;
      x0 = 24'($signed(loop_error));
      // Pole at z=1 (integrator) comes from the fixed unit y1 term when B1 equals B2 plus B3
      y_next = num_term(act_coef_reg[0], act_coef_reg[1], x0)
             + num_term(act_coef_reg[2], act_coef_reg[3], x1_reg)
             + num_term(act_coef_reg[4], act_coef_reg[5], x2_reg)
             + num_term(act_coef_reg[6], act_coef_reg[7], x3_reg)
             + y1_reg
             + den_term(act_coef_reg[8], y1_reg)
             - den_term(act_coef_reg[9], y2_reg)
             - den_term(act_coef_reg[10], y3_reg);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         x1_reg <= 24'sh0;
         x2_reg <= 24'sh0;
         x3_reg <= 24'sh0;
         y1_reg <= 24'sh0;
         y2_reg <= 24'sh0;
         y3_reg <= 24'sh0;
      end
      else if (boundary)
      begin
         x1_reg <= 24'($signed(loop_error));
         x2_reg <= x1_reg;
         x3_reg <= x2_reg;
         // Anti-windup: hold the state inside duty range
         if (y_next < 24'sh0)
            y1_reg <= 24'sh0;
         else if (y_next > 24'($signed({1'b0, act_limit_reg[7:0], 8'h00})))
            y1_reg <= 24'($signed({1'b0, act_limit_reg[7:0], 8'h00}));
         else
            y1_reg <= y_next;
         y2_reg <= y1_reg;
         y3_reg <= y2_reg;
      end
   end

   // Window feedforward and clamp
   always_comb
   begin
      logic signed [8:0] err;
      err = 9'($signed(loop_error));
      lin_duty = y1_reg[15:8];
      if (y1_reg[23:16] != 8'h00)
         lin_duty = 8'hFF;
      mode = DPWM_MODE_LINEAR;
      if (act_limit_reg[`DPWM_DCL_FF_BIT])
      begin
         if (err > $signed({1'b0, act_window_reg}))
            mode = DPWM_MODE_HIGH;
         else if (err < -$signed({1'b0, act_window_reg}))
            mode = DPWM_MODE_LOW;
      end
      case (mode)
         DPWM_MODE_LOW: duty_next = 8'h00;
         DPWM_MODE_HIGH: duty_next = act_limit_reg[7:0];
         DPWM_MODE_LINEAR: duty_next = lin_duty;
         default: duty_next = 8'h00;
      endcase
      if (duty_next > act_limit_reg[7:0])
         duty_next = act_limit_reg[7:0];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         duty_reg <= 8'h00;
      else if (boundary)
         duty_reg <= duty_next;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pwm_out <= 1'b0;
         duty_cycle <= 8'h00;
         cycle_start <= 1'b0;
      end
      else
      begin
         pwm_out <= (phase_reg < duty_reg);
         duty_cycle <= duty_reg;
         cycle_start <= boundary;
      end
   end

   // Monitor sequencer: voltage, current, temperature in turn
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         smp_cnt_reg <= 20'h00000;
         chan_reg <= DPWM_CH_VOUT;
         adc_start <= 1'b0;
         adc_channel <= 2'b00;
      end
      else
      begin
         adc_start <= 1'b0;
         if (smp_cnt_reg == 20'(SMP_CYC - 1))
         begin
            smp_cnt_reg <= 20'h00000;
            adc_start <= 1'b1;
            adc_channel <= chan_reg;
            case (chan_reg)
               DPWM_CH_VOUT: chan_reg <= DPWM_CH_IOUT;
               DPWM_CH_IOUT: chan_reg <= DPWM_CH_TEMP;
               default: chan_reg <= DPWM_CH_VOUT;
            endcase
         end
         else
            smp_cnt_reg <= smp_cnt_reg + 20'h00001;
      end
   end

   // Result capture, current corrected by temperature
   always_ff @(posedge clk or negedge reset_n)
   begin
      logic [8:0] corr;
      if (!reset_n)
      begin
         output_voltage_reading <= 8'h00;
         output_current_reading <= 8'h00;
         temperature_reading <= 8'h00;
      end
      else if (adc_valid)
      begin
         corr = 9'h000;
         case (adc_channel)
            2'b00: output_voltage_reading <= adc_data;
            2'b01:
            begin
               // Copper resistance rises ~0.4%/K: scale reading down
               if (temperature_reading > `DPWM_TEMP_REF)
                  corr = 9'((adc_data >> 5) *
                     ((temperature_reading - `DPWM_TEMP_REF) >> 4));
               output_current_reading <= (corr[8] || corr[7:0] > adc_data)
                  ? 8'h00 : adc_data - corr[7:0];
            end
            2'b10: temperature_reading <= adc_data;
            default: corr = 9'h000;
         endcase
      end
   end

   // Assertions
   duty_clamp_a: assert property (@(posedge clk) disable iff (!reset_n)
      boundary |=> duty_reg <= $past(act_limit_reg[7:0]))
      else $error("duty above limit");
   snap_high_a: assert property (@(posedge clk) disable iff (!reset_n)
      boundary && mode == DPWM_MODE_HIGH |=>
      duty_reg == $past(act_limit_reg[7:0]))
      else $error("no snap to limit");
   snap_low_a: assert property (@(posedge clk) disable iff (!reset_n)
      boundary && mode == DPWM_MODE_LOW |=> duty_reg == 8'h00)
      else $error("no snap to zero");
   ff_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !act_limit_reg[`DPWM_DCL_FF_BIT] |-> mode == DPWM_MODE_LINEAR)
      else $error("feedforward while off");
   sequence smp_tick_s;
      adc_start;
   endsequence
   sample_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
      smp_tick_s |-> smp_cnt_reg == 20'h00000)
      else $error("sample timing");
   shadow_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      !$past(boundary) |-> $stable(act_limit_reg))
      else $error("limit changed mid cycle");
   duty_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      !$past(boundary) |-> $stable(duty_reg))
      else $error("duty changed mid cycle");
   bus_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
      (avs_read || avs_write) && avs_waitrequest |-> ##[0:1] !avs_waitrequest)
      else $error("bus answer late");
   volt_track_a: assert property (@(posedge clk) disable iff (!reset_n)
      adc_valid && adc_channel == 2'b00 |=>
      output_voltage_reading == $past(adc_data))
      else $error("voltage not refreshed");
endmodule : dpwm_core

// file: dv/dpwm_adc_model.sv
// Behavioural converter answering conversion requests
`timescale 1ns/1ps
module dpwm_adc_model
#(
   parameter int LATENCY = 7
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Request side
   input wire logic adc_start,
   input wire logic [1:0] adc_channel,
   // Result side
   output logic [7:0] adc_data,
   output logic adc_valid
);
   int cnt_reg;
   logic [1:0] ch_reg;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_reg <= 0;
         ch_reg <= 2'h0;
         adc_valid <= 1'b0;
         adc_data <= 8'hA5;
      end
      else
      begin
         adc_valid <= 1'b0;
         // Outside a result the data bus keeps toggling
         adc_data <= ~adc_data;
         if (adc_start)
         begin
            cnt_reg <= LATENCY;
            ch_reg <= adc_channel;
         end
         else if (cnt_reg > 0)
         begin
            cnt_reg <= cnt_reg - 1;
            if (cnt_reg == 1)
            begin
               adc_valid <= 1'b1;
               adc_data <= 8'hC3 ^ {4{ch_reg}};
            end
         end
      end
   end
endmodule : dpwm_adc_model

// file: dv/testbench.sv
// Self-checking bench for the PWM loop core
`timescale 1ns/1ps
`include "dpwm_regs.svh"
module testbench;
   import dpwm_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] loop_error = 8'h00;
   logic [7:0] adc_data;
   logic adc_valid;
   logic [1:0] adc_channel;
   logic adc_start;
   logic pwm_out;
   logic [7:0] duty_cycle;
   logic cycle_start;
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   int gap = 0;
   int starts = 0;
   int mon_on = 0;
   int lim = 0;
   int coef[11];
   int v_m = 0;
   int i_m = 0;
   int t_m = 0;
   int crr = 0;
   logic [1:0] q_ch[$];
   logic [7:0] q_dat[$];
   logic [31:0] rd;
   always #4 clk = ~clk;
   dpwm_core uut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .loop_error(loop_error),
      .adc_data(adc_data), .adc_valid(adc_valid), .adc_channel(adc_channel),
      .adc_start(adc_start), .pwm_out(pwm_out), .duty_cycle(duty_cycle),
      .cycle_start(cycle_start));
   dpwm_adc_model adc (.clk(clk), .reset_n(reset_n), .adc_start(adc_start),
      .adc_channel(adc_channel), .adc_data(adc_data), .adc_valid(adc_valid));
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~wr;
      avs_write <= wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task wait_cs(input int n);
      repeat (n)
         do @(posedge clk); while (cycle_start !== 1'b1);
      repeat (3) @(posedge clk);
   endtask : wait_cs
   task set_dcl(input int l, input logic ff);
      // A lower limit only binds once the cycle after the running one has ended
      if (l > lim)
         lim = l;
      bus(1'b1, `DPWM_OFF_DUTY_LIMIT, {8'h00, 8'h10, 7'h00, ff, l[7:0]});
      wait_cs(2);
      lim = l;
   endtask : set_dcl
   task mode_is(input logic [1:0] m, input logic [7:0] d, input string s);
      bus(1'b0, `DPWM_OFF_STATUS, 32'h0);
      chk({22'h0, rd[9:0]}, {22'h0, m, d}, s);
   endtask : mode_is
   // Cycle limit and duty clamp watch
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc > 60000)
      begin
         fails++;
         finish_test();
      end
      if (mon_on != 0 && duty_cycle > lim[7:0])
         chk({24'h0, duty_cycle}, lim, "duty above limit");
      gap <= adc_start ? 0 : gap + 1;
      if (adc_start === 1'b1)
      begin
         starts <= starts + 1;
         if (starts > 0)
            chk(gap < (`DPWM_CLK_HZ / `DPWM_SAMPLE_HZ / 3), 1, "gap");
      end
      if (adc_valid === 1'b1)
      begin
         q_ch.push_back(adc_channel);
         q_dat.push_back(adc_data);
      end
   end
   initial
   begin
      void'($urandom(32'h168A));
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b0, `DPWM_OFF_DUTY_LIMIT, 32'h0);
      chk(rd, {8'h00, `DPWM_WINDOW_RESET, 7'h00, `DPWM_DCL_RESET}, "dcl");
      foreach (coef[i])
      begin
         coef[i] = $urandom_range(255);
         bus(1'b1, 4'(`DPWM_OFF_COEF_BASE + i), 32'(coef[i]));
      end
      foreach (coef[i])
      begin
         bus(1'b0, 4'(`DPWM_OFF_COEF_BASE + i), 32'h0);
         chk({24'h0, rd[7:0]}, coef[i], "coef readback");
      end
      $display("test registers done");
      set_dcl($urandom_range(64, 159), 1'b1);
      mon_on = 1;
      loop_error <= 8'h50;
      wait_cs(2);
      mode_is(DPWM_MODE_HIGH, lim[7:0], "snap high");
      loop_error <= 8'hB0;
      wait_cs(2);
      mode_is(DPWM_MODE_LOW, 8'h00, "snap low");
      loop_error <= 8'h04;
      wait_cs(2);
      bus(1'b0, `DPWM_OFF_STATUS, 32'h0);
      chk(32'(rd[9:8]), DPWM_MODE_LINEAR, "window linear");
      $display("test feedforward done");
      set_dcl(48, 1'b0);
      loop_error <= 8'h60;
      wait_cs(20);
      bus(1'b0, `DPWM_OFF_STATUS, 32'h0);
      chk(32'(rd[9:8]), DPWM_MODE_LINEAR, "ff off linear");
      chk(32'(duty_cycle <= 8'd48), 1, "clamp");
      $display("test clamp done");
      // Voltage, current, temperature, voltage again, then a corrected current
      wait (q_ch.size() >= 5);
      t_m = 0;
      foreach (q_ch[i])
      begin
         crr = 0;
         if (t_m > `DPWM_TEMP_REF)
            crr = (q_dat[i] / 32) * ((t_m - `DPWM_TEMP_REF) / 16);
         if (q_ch[i] == DPWM_CH_VOUT)
            v_m = q_dat[i];
         else if (q_ch[i] == DPWM_CH_IOUT)
            i_m = (crr > q_dat[i]) ? 0 : q_dat[i] - crr;
         else
            t_m = q_dat[i];
      end
      bus(1'b0, `DPWM_OFF_VOUT, 32'h0);
      chk(rd, v_m, "voltage reading");
      bus(1'b0, `DPWM_OFF_IOUT, 32'h0);
      chk(rd, i_m, "current reading");
      bus(1'b0, `DPWM_OFF_TEMP, 32'h0);
      chk(rd, t_m, "temperature reading");
      $display("test monitor done");
      finish_test();
   end
endmodule : testbench
